// >>> hdl/bbx_exec.sv
// Overview of operation
// - bit invert 57h flips one working-register bit only, two bytes, 4 cycles
// - after invert Z tracks a zero result, S cleared, C kept
// - bit clear 77h with selector 0 zeroes one bit, no flags, 4 cycles
// - bit set 77h with selector 1 sets one bit, no flags changed
// - second byte splits into 4-bit register, 3-bit index, 1-bit selector
// - bit OR 07h combines bit zero and indexed bit per selector, 6 cycles
// - bit OR keeps other bits, Z on zero result, S cleared, rest kept
// - bit XOR 27h works like bit OR using exclusive OR, 6 cycles
// - after bit XOR Z tracks zero result, S cleared, others preserved
// - branch on zero 37h selector 0 adds displacement when bit is 0, 10 cycles
// - branch on one 37h selector 1 branches when tested bit is 1
// - bit-test branches and calls leave all status flags unchanged
// - call pushes the following instruction address, then loads the target
// - call drops stack pointer by two, high byte at the lower address
// - call forms F6h 14 cycles, F4h 12 cycles, D4h 14 cycles, return 8 cycles
// - vector call fetches target high byte first, low byte from next location
// - return pops two stack bytes back into the program counter
// - flag updates are written to the flags register at D5h
`timescale 1ns/1ps
`default_nettype none

module bbx_exec
  import bbx_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire bbx_issue_s   issue,
  output logic              issue_ready,
  output logic              issue_take,
  input  wire logic [7:0]   wreg_base,
  output bbx_reg_req_s      reg_req,
  input  wire logic [7:0]   reg_rdata,
  input  wire logic [15:0]  sp_in,
  output bbx_stk_req_s      stk_req,
  input  wire logic [7:0]   stk_rdata,
  output logic [15:0]       pmem_addr,
  output logic              pmem_re,
  input  wire logic [7:0]   pmem_rdata,
  output logic              done,
  output logic              pc_we,
  output logic [15:0]       pc_out,
  output logic              sp_we,
  output logic [15:0]       sp_out
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic [1:0] rsync;
  logic       rst_n;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rsync <= 2'b00;
    else
      rsync <= {rsync[0], 1'b1};
  end

  assign rst_n = rsync[1];

  // ************************************************************
  // helpers
  // ************************************************************
  bbx_core_s   s;
  bbx_core_s   next_s;
  logic [2:0]  bidx;
  logic [7:0]  bmask;
  logic [7:0]  work_addr;
  logic        sup;
  logic [3:0]  cyc_of;
  logic        tst_hit;
  logic        lbit;

  assign bidx      = s.b2[B2_BIT_H:B2_BIT_L];
  assign bmask     = 8'h01 << bidx;
  assign work_addr = {wreg_base[7:4], s.b2[B2_REG_H:B2_REG_L]};
  assign tst_hit   = reg_rdata[bidx] == s.b2[B2_SEL];

  always_comb
  begin
    sup    = 1'b1;
    cyc_of = CYC_BIT_INVERT;
    unique case (issue.opcode)
      BIT_INVERT_OP:        cyc_of = CYC_BIT_INVERT;
      BIT_CLEAR_OP:         cyc_of = CYC_BIT_CLEAR;
      BIT_OR_OP, BIT_XOR_OP: cyc_of = CYC_BIT_LOGIC;
      BIT_TEST_BRANCH_OP:   cyc_of = CYC_BIT_TEST;
      DIRECT_TARGET_FORM:   cyc_of = CYC_CALL_DIR;
      PAIR_INDIRECT_FORM:   cyc_of = CYC_CALL_PAIR;
      VECTOR_INDIRECT_FORM: cyc_of = CYC_CALL_VEC;
      RETURN_OP:            cyc_of = CYC_RETURN;
      default:              sup = 1'b0;
    endcase
  end

  assign issue_ready = s.st == ST_IDLE;
  assign issue_take  = issue_ready & issue.valid & sup;
  assign done        = (s.st != ST_IDLE) && (s.cnt == s.ncyc);
  assign pc_we       = done & s.pc_load;
  assign sp_we       = done & s.sp_load;
  assign pc_out      = s.pc;
  assign sp_out      = s.sp;

  // ************************************************************
  // memory ports
  // ************************************************************
  always_comb
  begin
    reg_req   = '0;
    stk_req   = '0;
    pmem_addr = 16'h0000;
    pmem_re   = 1'b0;
    unique case (s.st)
      ST_RDA:
        reg_req.addr = (s.opc == PAIR_INDIRECT_FORM) ?
                       8'(s.b2 + {7'h00, s.step}) : work_addr;
      ST_RDB:
        reg_req.addr = s.b3;
      ST_RDF:
        reg_req.addr = FLAGS_ADDR;
      ST_WRD:
      begin
        reg_req.addr  = s.wr_full ? s.b3 : work_addr;
        reg_req.wdata = s.res;
        reg_req.we    = 1'b1;
      end
      ST_WRF:
      begin
        reg_req.addr  = FLAGS_ADDR;
        reg_req.wdata = s.a;
        reg_req.we    = 1'b1;
      end
      ST_VEC:
      begin
        pmem_addr = 16'({8'h00, s.b2} + {15'h0000, s.step});
        pmem_re   = 1'b1;
      end
      ST_PUSH:
      begin
        stk_req.addr  = s.step ? 16'(s.sp - LEN_TWO) : 16'(s.sp - 16'h0001);
        stk_req.wdata = s.step ? s.ret[15:8] : s.ret[7:0];
        stk_req.we    = 1'b1;
      end
      ST_POP:
      begin
        stk_req.addr = 16'(s.sp + {15'h0000, s.step});
        stk_req.re   = 1'b1;
      end
      default:
        reg_req = '0;
    endcase
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    next_s = s;
    lbit   = 1'b0;
    unique case (s.st)
      ST_IDLE:
      if (issue_take)
      begin
        next_s.opc     = issue.opcode;
        next_s.b2      = issue.op2;
        next_s.b3      = issue.op3;
        next_s.pc      = issue.pc;
        next_s.cnt     = 4'h1;
        next_s.ncyc    = cyc_of;
        next_s.step    = 1'b0;
        next_s.wr_full = 1'b0;
        next_s.pc_load = 1'b0;
        next_s.sp_load = 1'b0;
        next_s.sp      = sp_in;
        next_s.ret     = 16'(issue.pc + LEN_TWO);
        next_s.st      = ST_RDA;
        if (issue.opcode == DIRECT_TARGET_FORM)
        begin
          next_s.pc  = {issue.op2, issue.op3};
          next_s.ret = 16'(issue.pc + LEN_THREE);
          next_s.st  = ST_PUSH;
        end
        else if (issue.opcode == VECTOR_INDIRECT_FORM)
          next_s.st = ST_VEC;
        else if (issue.opcode == RETURN_OP)
          next_s.st = ST_POP;
      end
      ST_RDA:
      begin
        next_s.a = reg_rdata;
        if (s.opc == BIT_INVERT_OP)
        begin
          next_s.res = reg_rdata ^ bmask;
          next_s.st  = ST_RDF;
        end
        else if (s.opc == BIT_CLEAR_OP)
        begin
          next_s.res = s.b2[B2_SEL] ? (reg_rdata | bmask)
                                    : (reg_rdata & ~bmask);
          next_s.st  = ST_WRD;
        end
        else if (s.opc == BIT_TEST_BRANCH_OP)
        begin
          next_s.pc = tst_hit ?
            16'(s.pc + LEN_THREE + {{8{s.b3[7]}}, s.b3}) :
            16'(s.pc + LEN_THREE);
          next_s.pc_load = 1'b1;
          next_s.st      = ST_WAIT;
        end
        else if (s.opc == PAIR_INDIRECT_FORM)
        begin
          next_s.pc   = s.step ? {s.pc[15:8], reg_rdata}
                               : {reg_rdata, s.pc[7:0]};
          next_s.step = ~s.step;
          next_s.st   = s.step ? ST_PUSH : ST_RDA;
        end
        else
          next_s.st = ST_RDB;
      end
      ST_RDB:
      begin
        lbit = (s.opc == BIT_XOR_OP) ? (s.a[0] ^ reg_rdata[bidx])
                                     : (s.a[0] | reg_rdata[bidx]);
        next_s.wr_full = s.b2[B2_SEL];
        if (!s.b2[B2_SEL])
          next_s.res = {s.a[7:1], lbit};
        else
          next_s.res = lbit ? (reg_rdata | bmask)
                            : (reg_rdata & ~bmask);
        next_s.st = ST_RDF;
      end
      ST_RDF:
      begin
        next_s.a        = reg_rdata;
        next_s.a[FLG_Z] = s.res == 8'h00;
        next_s.a[FLG_S] = 1'b0;
        next_s.st       = ST_WRD;
      end
      ST_WRD:
        next_s.st = (s.opc == BIT_CLEAR_OP) ? ST_WAIT : ST_WRF;
      ST_WRF:
        next_s.st = ST_WAIT;
      ST_VEC:
      begin
        next_s.pc   = s.step ? {s.pc[15:8], pmem_rdata}
                             : {pmem_rdata, s.pc[7:0]};
        next_s.step = ~s.step;
        next_s.st   = s.step ? ST_PUSH : ST_VEC;
      end
      ST_PUSH:
      begin
        next_s.step = ~s.step;
        if (s.step)
        begin
          next_s.sp      = 16'(s.sp - LEN_TWO);
          next_s.sp_load = 1'b1;
          next_s.pc_load = 1'b1;
          next_s.st      = ST_WAIT;
        end
      end
      ST_POP:
      begin
        next_s.pc   = s.step ? {s.pc[15:8], stk_rdata}
                             : {stk_rdata, s.pc[7:0]};
        next_s.step = ~s.step;
        if (s.step)
        begin
          next_s.sp      = 16'(s.sp + LEN_TWO);
          next_s.sp_load = 1'b1;
          next_s.pc_load = 1'b1;
          next_s.st      = ST_WAIT;
        end
      end
      ST_WAIT:
        next_s.st = ST_WAIT;
      default:
        next_s.st = ST_IDLE;
    endcase
    if (s.st != ST_IDLE)
    begin
      if (s.cnt == s.ncyc)
        next_s.st = ST_IDLE;
      else
        next_s.cnt = 4'(s.cnt + 4'h1);
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s <= '{st: ST_IDLE, default: '0};
    else
      s <= next_s;
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic flag_wr;
  assign flag_wr = reg_req.we && reg_req.addr == FLAGS_ADDR;
  sequence take_op(logic [7:0] op);
    issue_take && issue.opcode == op;
  endsequence
  sequence quiet_then_done;
    !done [*3] ##1 done;
  endsequence

  invert_timing_a: assert property (take_op(BIT_INVERT_OP) |=>
    quiet_then_done)
    else $error("bit invert not finished in 4 cycles");
  invert_bit_a: assert property (s.st == ST_WRD &&
    s.opc == BIT_INVERT_OP |-> reg_req.wdata == ($past(reg_rdata, 2) ^ bmask))
    else $error("bit invert changed wrong bits");
  invert_flags_a: assert property (s.st == ST_WRF &&
    s.opc == BIT_INVERT_OP |-> !reg_req.wdata[FLG_S] &&
    reg_req.wdata[FLG_Z] == (s.res == 8'h00) &&
    reg_req.wdata[FLG_C] == $past(reg_rdata[FLG_C], 2))
    else $error("bit invert flags wrong");
  clear_noflag_a: assert property (take_op(BIT_CLEAR_OP) |=>
    !flag_wr [*4])
    else $error("bit clear or set wrote flags");
  setclr_value_a: assert property (s.st == ST_WRD &&
    s.opc == BIT_CLEAR_OP |-> reg_req.wdata == (s.b2[0] ?
    (s.a | bmask) : (s.a & ~bmask)))
    else $error("bit set or clear value wrong");
  field_split_a: assert property (s.st == ST_RDA &&
    s.opc != PAIR_INDIRECT_FORM |-> reg_req.addr ==
    {wreg_base[7:4], s.b2[7:4]})
    else $error("working register field wrong");
  or_low_bit_a: assert property (s.st == ST_WRD &&
    s.opc == BIT_OR_OP && !s.b2[0] |-> reg_req.wdata == {$past(s.a[7:1]),
    $past(s.a[0]) | $past(reg_rdata[bidx], 2)})
    else $error("bit or to bit zero wrong");
  xor_timing_a: assert property (take_op(BIT_XOR_OP) |=>
    !done [*2] ##1 quiet_then_done)
    else $error("bit xor not finished in 6 cycles");
  branch_pc_a: assert property (s.st == ST_RDA &&
    s.opc == BIT_TEST_BRANCH_OP |=> s.pc == ($past(tst_hit) ?
    16'($past(s.pc) + 16'h0003 + {{8{s.b3[7]}}, s.b3}) :
    16'($past(s.pc) + 16'h0003)))
    else $error("bit test branch target wrong");
  branch_noflag_a: assert property (take_op(BIT_TEST_BRANCH_OP) |=>
    !flag_wr [*8] ##2 done)
    else $error("bit test branch timing or flags wrong");
  push_order_a: assert property (s.st == ST_PUSH && !s.step |->
    stk_req.we && stk_req.wdata == s.ret[7:0] &&
    stk_req.addr == 16'(s.sp - 16'h0001) ##1
    stk_req.we && stk_req.wdata == s.ret[15:8] &&
    stk_req.addr == 16'(s.sp - 16'h0002))
    else $error("call push order wrong");
  pair_timing_a: assert property (take_op(PAIR_INDIRECT_FORM) |=>
    !done [*8] ##4 done && sp_we && pc_we)
    else $error("pair call not finished in 12 cycles");
  vector_fetch_a: assert property (s.st == ST_VEC && s.step |=>
    s.pc[7:0] == $past(pmem_rdata) &&
    $past(pmem_addr) == 16'({8'h00, s.b2} + 16'h0001))
    else $error("vector call fetch wrong");
endmodule

`default_nettype wire

// >>> hdl/bbx_pkg.sv
package bbx_pkg;

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] BIT_INVERT_OP        = 8'h57;
  localparam logic [7:0] BIT_CLEAR_OP         = 8'h77;
  localparam logic [7:0] BIT_OR_OP            = 8'h07;
  localparam logic [7:0] BIT_XOR_OP           = 8'h27;
  localparam logic [7:0] BIT_TEST_BRANCH_OP   = 8'h37;
  localparam logic [7:0] DIRECT_TARGET_FORM   = 8'hF6;
  localparam logic [7:0] PAIR_INDIRECT_FORM   = 8'hF4;
  localparam logic [7:0] VECTOR_INDIRECT_FORM = 8'hD4;
  localparam logic [7:0] RETURN_OP            = 8'hAF;

  // ************************************************************
  // cycle counts and lengths
  // ************************************************************
  localparam logic [3:0]  CYC_BIT_INVERT = 4'h4;
  localparam logic [3:0]  CYC_BIT_CLEAR  = 4'h4;
  localparam logic [3:0]  CYC_BIT_LOGIC  = 4'h6;
  localparam logic [3:0]  CYC_BIT_TEST   = 4'hA;
  localparam logic [3:0]  CYC_CALL_DIR   = 4'hE;
  localparam logic [3:0]  CYC_CALL_PAIR  = 4'hC;
  localparam logic [3:0]  CYC_CALL_VEC   = 4'hE;
  localparam logic [3:0]  CYC_RETURN     = 4'h8;
  localparam logic [15:0] LEN_TWO        = 16'h0002;
  localparam logic [15:0] LEN_THREE      = 16'h0003;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam logic [7:0] FLAGS_ADDR = 8'hD5;
  localparam int FLG_C    = 7;
  localparam int FLG_Z    = 6;
  localparam int FLG_S    = 5;
  localparam int B2_REG_H = 7;
  localparam int B2_REG_L = 4;
  localparam int B2_BIT_H = 3;
  localparam int B2_BIT_L = 1;
  localparam int B2_SEL   = 0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_RDA  = 10'h002,
    ST_RDB  = 10'h004,
    ST_RDF  = 10'h008,
    ST_WRD  = 10'h010,
    ST_WRF  = 10'h020,
    ST_VEC  = 10'h040,
    ST_PUSH = 10'h080,
    ST_POP  = 10'h100,
    ST_WAIT = 10'h200
  } bbx_state_e;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [7:0]  op2;
    logic [7:0]  op3;
    logic [15:0] pc;
  } bbx_issue_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } bbx_reg_req_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } bbx_stk_req_s;

  typedef struct packed {
    bbx_state_e  st;
    logic        step;
    logic [3:0]  cnt;
    logic [3:0]  ncyc;
    logic [7:0]  opc;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [15:0] pc;
    logic [15:0] ret;
    logic [15:0] sp;
    logic [7:0]  a;
    logic [7:0]  res;
    logic        wr_full;
    logic        pc_load;
    logic        sp_load;
  } bbx_core_s;

endpackage

// >>> sim/bbx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module bbx_mem_model
  import bbx_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire bbx_reg_req_s reg_req,
  output logic [7:0]        reg_rdata,
  input  wire bbx_stk_req_s stk_req,
  output logic [7:0]        stk_rdata,
  input  wire logic [15:0]  pmem_addr,
  input  wire logic         pmem_re,
  output logic [7:0]        pmem_rdata
);
  // ************************************************************
  // register file, stack and program store
  // ************************************************************
  logic [7:0] rf  [0:255];
  logic [7:0] stk [0:255];
  logic [7:0] pm  [0:255];
  logic [7:0] junk;

  // unselected read lines toggle every half period
  assign junk = clk_sys ? 8'hA5 : 8'h5A;

  always @(posedge clk_sys)
  begin
    if (reg_req.we)
      rf[reg_req.addr] <= reg_req.wdata;
    if (stk_req.we)
      stk[stk_req.addr[7:0]] <= stk_req.wdata;
  end

  assign reg_rdata  = rf[reg_req.addr];
  assign stk_rdata  = stk_req.re ? stk[stk_req.addr[7:0]] : junk;
  assign pmem_rdata = pmem_re ? pm[pmem_addr[7:0]] : junk;
endmodule

`default_nettype wire

// >>> sim/test_bit_ops_branch_call_exec.sv
`timescale 1ns/1ps
`default_nettype none

module test_bit_ops_branch_call_exec
  import bbx_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  typedef struct packed {
    logic [7:0]  opc;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [7:0]  w;
    logic [7:0]  f;
    logic [7:0]  ea;
    logic [7:0]  ev;
    logic [7:0]  ef;
    logic [3:0]  cyc;
    logic [15:0] epc;
  } bbx_row_s;

  logic         clk_sys;
  logic         arst_n;
  bbx_issue_s   issue;
  logic         issue_ready;
  logic         issue_take;
  logic [7:0]   wreg_base;
  bbx_reg_req_s reg_req;
  logic [7:0]   reg_rdata;
  logic [15:0]  sp_in;
  bbx_stk_req_s stk_req;
  logic [7:0]   stk_rdata;
  logic [15:0]  pmem_addr;
  logic         pmem_re;
  logic [7:0]   pmem_rdata;
  logic         done;
  logic         pc_we;
  logic [15:0]  pc_out;
  logic         sp_we;
  logic [15:0]  sp_out;
  int           error_cnt;
  int           total_checks;
  int           cyc;
  logic         pw;
  logic         sw;
  logic [15:0]  po;
  logic [15:0]  so;

  // opcode row: work reg C1 preset w, reg 01 preset 03, flags preset f
  bbx_row_s rows [14] = '{
    '{8'h57, 8'h12, 8'h00, 8'h07, 8'hA7, 8'hC1, 8'h05, 8'h87, 4'h4, 16'h0},
    '{8'h57, 8'h10, 8'h00, 8'h01, 8'h27, 8'hC1, 8'h00, 8'h47, 4'h4, 16'h0},
    '{8'h77, 8'h12, 8'h00, 8'h07, 8'hA7, 8'hC1, 8'h05, 8'hA7, 4'h4, 16'h0},
    '{8'h77, 8'h17, 8'h00, 8'h07, 8'hA7, 8'hC1, 8'h0F, 8'hA7, 4'h4, 16'h0},
    '{8'h07, 8'h12, 8'h01, 8'h07, 8'hA7, 8'hC1, 8'h07, 8'h87, 4'h6, 16'h0},
    '{8'h07, 8'h15, 8'h01, 8'h07, 8'hA7, 8'h01, 8'h07, 8'h87, 4'h6, 16'h0},
    '{8'h07, 8'h18, 8'h01, 8'h00, 8'h27, 8'hC1, 8'h00, 8'h47, 4'h6, 16'h0},
    '{8'h27, 8'h12, 8'h01, 8'h07, 8'hA7, 8'hC1, 8'h06, 8'h87, 4'h6, 16'h0},
    '{8'h27, 8'h15, 8'h01, 8'h07, 8'hA7, 8'h01, 8'h07, 8'h87, 4'h6, 16'h0},
    '{8'h27, 8'h12, 8'h01, 8'h01, 8'h27, 8'hC1, 8'h00, 8'h47, 4'h6, 16'h0},
    '{8'h37, 8'h16, 8'h80, 8'h07, 8'hA7, 8'hC1, 8'h07, 8'hA7, 4'hA,
      16'h0083},
    '{8'h37, 8'h13, 8'h7F, 8'h07, 8'hA7, 8'hC1, 8'h07, 8'hA7, 4'hA,
      16'h0182},
    '{8'h37, 8'h12, 8'h80, 8'h07, 8'hA7, 8'hC1, 8'h07, 8'hA7, 4'hA,
      16'h0103},
    '{8'h37, 8'h17, 8'h7F, 8'h07, 8'hA7, 8'hC1, 8'h07, 8'hA7, 4'hA,
      16'h0103}
  };

  logic [7:0] cf  [3] = '{8'hF6, 8'hF4, 8'hD4};
  logic [7:0] cb2 [3] = '{8'h35, 8'h20, 8'h40};
  logic [7:0] clo [3] = '{8'h4A, 8'h49, 8'h49};
  int         ccy [3] = '{14, 12, 14};

  // ************************************************************
  // design and far side
  // ************************************************************
  bbx_exec u_dut (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .issue       (issue),
    .issue_ready (issue_ready),
    .issue_take  (issue_take),
    .wreg_base   (wreg_base),
    .reg_req     (reg_req),
    .reg_rdata   (reg_rdata),
    .sp_in       (sp_in),
    .stk_req     (stk_req),
    .stk_rdata   (stk_rdata),
    .pmem_addr   (pmem_addr),
    .pmem_re     (pmem_re),
    .pmem_rdata  (pmem_rdata),
    .done        (done),
    .pc_we       (pc_we),
    .pc_out      (pc_out),
    .sp_we       (sp_we),
    .sp_out      (sp_out)
  );

  bbx_mem_model u_mem (
    .clk_sys    (clk_sys),
    .reg_req    (reg_req),
    .reg_rdata  (reg_rdata),
    .stk_req    (stk_req),
    .stk_rdata  (stk_rdata),
    .pmem_addr  (pmem_addr),
    .pmem_re    (pmem_re),
    .pmem_rdata (pmem_rdata)
  );

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic run(input logic [7:0] opc, b2, b3, input logic [15:0] pc);
    int n;
    n = 0;
    issue = '{1'b1, opc, b2, b3, pc};
    #2;
    while (issue_take !== 1'b1 && n < 30)
    begin
      @(negedge clk_sys);
      #2;
      n++;
    end
    @(negedge clk_sys);
    issue.valid = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 30)
    begin
      @(negedge clk_sys);
      cyc++;
    end
    pw = pc_we;
    po = pc_out;
    sw = sp_we;
    so = sp_out;
    @(negedge clk_sys);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ************************************************************
  // clock, watchdog
  // ************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #75000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    arst_n = 1'b0;
    issue = '0;
    wreg_base = 8'hC0;
    sp_in = 16'h0002;
    repeat (4) @(negedge clk_sys);
    chk(16'(issue_ready), 16'h1, "ready in reset");
    chk(16'(done), 16'h0, "done in reset");
    arst_n = 1'b1;
    // unsupported opcode is never taken
    issue = '{1'b1, 8'h00, 8'h12, 8'h00, 16'h0100};
    repeat (5)
    begin
      @(negedge clk_sys);
      chk(16'(issue_take), 16'h0, "odd opcode taken");
    end
    issue.valid = 1'b0;
    $display("reset and refusal test done");

    foreach (rows[i])
    begin
      u_mem.rf[8'hC1] = rows[i].w;
      u_mem.rf[8'h01] = 8'h03;
      u_mem.rf[FLAGS_ADDR] = rows[i].f;
      run(rows[i].opc, rows[i].b2, rows[i].b3, 16'h0100);
      chk(16'(cyc), 16'(rows[i].cyc), "cycles");
      chk(16'(u_mem.rf[rows[i].ea]), 16'(rows[i].ev), "result");
      chk(16'(u_mem.rf[FLAGS_ADDR]), 16'(rows[i].ef), "flags");
      chk(16'(pw), 16'(rows[i].epc != 16'h0), "pc write");
      chk(16'(sw), 16'h0, "sp write");
      if (rows[i].epc != 16'h0)
        chk(po, rows[i].epc, "branch target");
      $display("row %0d test done", i);
    end

    for (int k = 0; k < 3; k++)
    begin
      sp_in = 16'h0002;
      u_mem.stk[0] = 8'hEE;
      u_mem.stk[1] = 8'hEE;
      u_mem.rf[8'h20] = 8'h35;
      u_mem.rf[8'h21] = 8'h21;
      u_mem.pm[8'h40] = 8'h35;
      u_mem.pm[8'h41] = 8'h21;
      u_mem.rf[FLAGS_ADDR] = 8'hA7;
      run(cf[k], cb2[k], 8'h21, 16'h1A47);
      chk(16'(cyc), 16'(ccy[k]), "call cycles");
      chk(16'({pw, sw}), 16'h3, "call strobes");
      chk(po, 16'h3521, "call target");
      chk(so, 16'h0000, "call sp");
      chk(16'(u_mem.stk[0]), 16'h1A, "ret high");
      chk(16'(u_mem.stk[1]), 16'(clo[k]), "ret low");
      chk(16'(u_mem.rf[FLAGS_ADDR]), 16'hA7, "call flags");
      $display("call form %0d test done", k);
    end

    sp_in = 16'h0000;
    run(RETURN_OP, 8'h00, 8'h00, 16'h3521);
    chk(16'(cyc), 16'h8, "return cycles");
    chk(po, 16'h1A49, "return pc");
    chk(so, 16'h0002, "return sp");
    chk(16'(sw), 16'h1, "return sp write");
    $display("return test done");

    // reset in mid-instruction stops the write-back
    u_mem.rf[8'hC1] = 8'h07;
    issue = '{1'b1, BIT_INVERT_OP, 8'h12, 8'h00, 16'h0100};
    @(negedge clk_sys);
    issue.valid = 1'b0;
    @(negedge clk_sys);
    arst_n = 1'b0;
    #2;
    chk(16'(issue_ready), 16'h1, "ready after reset");
    chk(16'(done), 16'h0, "done after reset");
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(16'(u_mem.rf[8'hC1]), 16'h07, "aborted write");
    run(BIT_INVERT_OP, 8'h12, 8'h00, 16'h0100);
    chk(16'(u_mem.rf[8'hC1]), 16'h05, "recovered");
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule

`default_nettype wire
